// ### hdl/prms_regs.vh
// register map constants for the paged register select block
// assumes inclusion by the design files of this block only
`ifndef PRMS_REGS_VH
`define PRMS_REGS_VH
`define PRMS_ADDR_W        7
`define PRMS_PAGE_SEL_ADDR 7'h7F
`define PRMS_PAGE_CTRL     8'h00
`define PRMS_PAGE_RXBUF    8'h01
`define PRMS_PAGE_TXBUF    8'h02
`define PRMS_PAGE_TEST     8'h03
`define PRMS_PAGE_RESET    8'h00
`define PRMS_AINC_BIT      7
`define PRMS_UNLOCK_RESET  1'b0
`endif

// ### hdl/prms_buf.v
// one byte-wide buffer memory, registered read data
// assumes one write port and one read port in the same clock domain
`timescale 1ns/1ps
module prms_buf #(
   parameter AW = 7,
   parameter DW = 8
) (
   // clock
   input  wire          clk,
   // write port
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   // read port
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// ### hdl/prms_top.v
// page selection and buffer access for the paged host register space
// assumes a serial host front end that delivers decoded address and
// data byte strobes synchronous to clk; page 0 registers live outside
`timescale 1ns/1ps
`include "prms_regs.vh"

// Summary of operation
// - page select register at 0x7F is decoded on every page
// - page 00 control/status, 01 receiver buffers, 02 transmitter buffers
// - receiver page shows C and U bits of last completed block
// - host writes to transmitter page set outgoing C and U bits
// - transmitter page reads return what the host wrote
// - page 03 stays closed unless the private unlock is given
// - enabled page 0 status flags may drive the interrupt output
// - address byte holds seven address bits and auto-increment bit
// - with auto-increment the address steps by one per byte
module prms_top #(
   parameter AW = `PRMS_ADDR_W
) (
   // clock and reset
   input  wire          clk,
   input  wire          nrst,
   // host side, from serial front end
   input  wire          addr_valid,
   input  wire [7:0]    addr_byte,
   input  wire          wr_stb,
   input  wire [7:0]    wr_data,
   input  wire          rd_stb,
   output reg  [7:0]    rd_data,
   output reg           rd_valid,
   // test unlock from a private source
   input  wire          test_unlock,
   // page 0 register block
   output wire          ctrl_wr,
   output wire          ctrl_rd,
   output wire [AW-1:0] ctrl_addr,
   input  wire [7:0]    ctrl_rdata,
   input  wire          ctrl_irq,
   // receiver block capture port
   input  wire          rx_cap_we,
   input  wire [AW-1:0] rx_cap_addr,
   input  wire [7:0]    rx_cap_data,
   // transmitter block fetch port
   input  wire [AW-1:0] interface_transmitter_addr,
   output wire [7:0]    interface_transmitter_data,
   // test page strobes, interrupt, state
   output wire          test_wr,
   output wire          test_rd,
   output wire          int_n_oe,
   output reg  [7:0]    page_select,
   output reg           auto_inc
);
   reg  [AW-1:0] reg_addr;
   reg           unlocked;
   reg           rd_pend;
   reg  [7:0]    pend_page;
   wire [7:0]    rx_rdata;
   wire [7:0]    tx_rdata;
   wire [7:0]    tx_host_rdata;
   wire          sel_reg;
   wire          on_ctrl;
   wire          on_rx;
   wire          on_tx;
   wire          on_test;
   wire          xfer;
   wire [AW-1:0] next_addr;

   // the select register wins over every page at its address
   assign sel_reg = (reg_addr == `PRMS_PAGE_SEL_ADDR);
   assign on_ctrl = !sel_reg && page_select == `PRMS_PAGE_CTRL;
   assign on_rx   = !sel_reg && page_select == `PRMS_PAGE_RXBUF;
   assign on_tx   = !sel_reg && page_select == `PRMS_PAGE_TXBUF;
   // test page gated by the unlock; locked access reads zero
   assign on_test = !sel_reg && page_select == `PRMS_PAGE_TEST
                    && unlocked;
   assign xfer    = wr_stb | rd_stb;

   // reserved page 0 addresses pass through; host must avoid them
   assign ctrl_wr   = wr_stb & on_ctrl;
   assign ctrl_rd   = rd_stb & on_ctrl;
   assign ctrl_addr = reg_addr;
   assign test_wr   = wr_stb & on_test;
   assign test_rd   = rd_stb & on_test;

   // open-drain interrupt: enable high pulls the line low
   assign int_n_oe = ctrl_irq;

   // wraps inside the page since the address is only seven bits
   assign next_addr = reg_addr + {{(AW-1){1'b0}}, 1'b1};

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_addr    <= {AW{1'b0}};
         auto_inc    <= 1'b0;
         page_select <= `PRMS_PAGE_RESET;
         unlocked    <= `PRMS_UNLOCK_RESET;
      end else begin
         if (test_unlock) begin
            unlocked <= 1'b1;
         end
         if (addr_valid) begin
            reg_addr <= addr_byte[AW-1:0];
            auto_inc <= addr_byte[`PRMS_AINC_BIT];
         end else if (xfer && auto_inc) begin
            reg_addr <= next_addr;
         end
         if (wr_stb && sel_reg) begin
            page_select <= wr_data;
         end
      end
   end

   // receiver buffer: device captures, host reads
   prms_buf #(.AW(AW), .DW(8)) u_rxbuf (
      .clk   (clk),
      .we    (rx_cap_we),
      .waddr (rx_cap_addr),
      .wdata (rx_cap_data),
      .raddr (reg_addr),
      .rdata (rx_rdata)
   );

   // transmitter buffer: host writes, encoder fetches
   prms_buf #(.AW(AW), .DW(8)) u_txbuf (
      .clk   (clk),
      .we    (wr_stb & on_tx),
      .waddr (reg_addr),
      .wdata (wr_data),
      .raddr (interface_transmitter_addr),
      .rdata (tx_rdata)
   );

   // readback copy keeps the encoder fetch port free of host reads
   prms_buf #(.AW(AW), .DW(8)) u_txshadow (
      .clk   (clk),
      .we    (wr_stb & on_tx),
      .waddr (reg_addr),
      .wdata (wr_data),
      .raddr (reg_addr),
      .rdata (tx_host_rdata)
   );

   assign interface_transmitter_data = tx_rdata;

   // read data two cycles after rd_stb, after the buffer's registered read
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_pend   <= 1'b0;
         pend_page <= `PRMS_PAGE_RESET;
         rd_data   <= 8'h00;
         rd_valid  <= 1'b0;
      end else begin
         rd_pend  <= rd_stb;
         rd_valid <= rd_pend;
         if (rd_stb) begin
            if (sel_reg) begin
               pend_page <= 8'hFF;
            end else if (page_select == `PRMS_PAGE_TEST && !unlocked) begin
               pend_page <= 8'hFE;
            end else begin
               pend_page <= page_select;
            end
         end
         if (rd_pend) begin
            case (pend_page)
               8'hFF:             rd_data <= page_select;
               `PRMS_PAGE_CTRL:   rd_data <= ctrl_rdata;
               `PRMS_PAGE_RXBUF:  rd_data <= rx_rdata;
               `PRMS_PAGE_TXBUF:  rd_data <= tx_host_rdata;
               default:           rd_data <= 8'h00;
            endcase
         end
      end
   end
endmodule

// ### bench/prms_top_checker.sv
// port assertions for the page select block
// assumes binding onto prms_top, single clock domain
`timescale 1ns/1ps
module prms_top_checker #(parameter AW = 7) (
   // strobes and flags
   input wire          clk, nrst, addr_valid, wr_stb, rd_stb, rd_valid,
   input wire          ctrl_wr, ctrl_rd, ctrl_irq, int_n_oe, auto_inc,
   input wire          test_wr, test_rd,
   // bytes and addresses
   input wire [7:0]    addr_byte, wr_data, page_select,
   input wire [AW-1:0] ctrl_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_sel; addr_valid && addr_byte[6:0] == 7'h7F; endsequence
   property p_rst; !$past(nrst) |-> page_select == 8'h00; endproperty
   property p_sel; s_sel ##1 wr_stb |=> page_select == $past(wr_data);
   endproperty
   property p_lock; test_wr || test_rd |-> page_select == 8'h03; endproperty
   property p_irq; int_n_oe == ctrl_irq; endproperty
   property p_cwr; ctrl_wr |-> wr_stb && page_select == 8'h00; endproperty
   property p_crd; ctrl_rd |-> rd_stb && page_select == 8'h00; endproperty
   property p_rd; rd_stb |-> ##2 rd_valid; endproperty
   // auto-inc bit latch and page 0 address step are checked apart; the step check never sees the 0x7F wrap
   property p_adr; addr_valid |=> auto_inc == $past(addr_byte[7]);
   endproperty
   property p_inc; (ctrl_wr || ctrl_rd) && auto_inc && !addr_valid
      |=> ctrl_addr == $past(ctrl_addr) + 1'b1; endproperty
   a_rst: assert property (p_rst) else $error("page not zero");
   a_sel: assert property (p_sel) else $error("page not set");
   a_lock: assert property (p_lock) else $error("test strobe");
   a_irq: assert property (p_irq) else $error("irq drive");
   a_cwr: assert property (p_cwr) else $error("ctrl write");
   a_crd: assert property (p_crd) else $error("ctrl read");
   a_rd: assert property (p_rd) else $error("read late");
   a_adr: assert property (p_adr) else $error("ainc bit");
   a_inc: assert property (p_inc) else $error("no step");
endmodule

// ### bench/prms_host.sv
// host model: byte strobes as a serial front end hands them over
// assumes callers keep off reserved page 0 addresses
`timescale 1ns/1ps
module prms_host (
   // clock
   input  wire       clk,
   // byte strobes
   output reg        addr_valid = 0, wr_stb = 0, rd_stb = 0,
   output reg  [7:0] addr_byte = 0, wr_data = 0
);
   // k: 0 address, 1 write, 2 read, 3 idle; strobes hold until the next put
   task put(input [1:0] k, input [7:0] b);
      @(posedge clk);
      addr_valid <= k == 0;
      wr_stb <= k == 1;
      rd_stb <= k == 2;
      addr_byte <= b;
      wr_data <= k == 1 ? b : ~b; // non-write data is the inverse of the byte argument
   endtask
endmodule

// ### bench/prms_top_tb_top.sv
// self-checking bench for the page select block
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
module prms_top_tb_top;
   reg        clk = 0, nrst = 0, test_unlock = 0, ctrl_irq = 0, rx_cap_we = 0;
   reg  [6:0] rx_cap_addr = 0, interface_transmitter_addr = 7'h05;
   reg  [7:0] rx_cap_data = 0, ctrl_rdata = 0, v = 0;
   wire       addr_valid, wr_stb, rd_stb, rd_valid;
   wire [7:0] addr_byte, wr_data, rd_data, interface_transmitter_data;
   integer    seed = 60018, failures = 0, num_checks = 0, cyc = 0;
   reg  [7:0] q[$];
   prms_host h (.*);
   prms_top uut (.*, .ctrl_wr(), .ctrl_rd(), .ctrl_addr(), .test_wr(),
      .test_rd(), .int_n_oe(), .page_select(), .auto_inc());
   task finish_test;
      if (failures == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task cmp(input string n, input [7:0] e, s);
      num_checks++;
      if (e !== s) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task rd(input [7:0] e); q.push_back(e); h.put(2, 8'h00); endtask
   task sel(input [7:0] p); h.put(0, 8'h7F); h.put(1, p); endtask
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      ctrl_irq <= $random(seed);
      if (rd_valid === 1'b1) cmp("rd_data", q.pop_front(), rd_data);
      if (cyc == 2000) begin failures++; finish_test; end
   end
   initial begin
      ctrl_rdata = $random(seed);
      v = $random(seed);
      repeat (16) @(posedge clk);
      nrst <= 1;
      h.put(0, 8'h7F); rd(8'h00);
      h.put(0, 8'h90); h.put(1, v); rd(ctrl_rdata);
      h.put(3, v);
      rx_cap_we <= 1; rx_cap_addr <= 7'h03; rx_cap_data <= ~v;
      h.put(3, v);
      rx_cap_we <= 0;
      sel(8'h01); h.put(0, 8'h03); rd(~v);
      sel(8'h02); h.put(0, 8'h85); h.put(1, v); h.put(1, ~v);
      h.put(0, 8'h85); rd(v); rd(~v);
      h.put(3, v);
      cmp("tx_data", v, interface_transmitter_data);
      sel(8'h03); h.put(0, 8'h01); h.put(1, v); rd(8'h00);
      test_unlock <= 1;
      h.put(0, 8'h01); h.put(1, v); rd(8'h00);
      h.put(0, 8'h7F); rd(8'h03); h.put(3, v);
      repeat (6) @(posedge clk);
      finish_test;
   end
endmodule
bind prms_top prms_top_checker #(.AW(AW)) chk (.*);
